// *** rtl/dorb_consts.vh ***
// Constants of the DDR output register block
`ifndef DORB_CONSTS_VH
`define DORB_CONSTS_VH

// ==========================================
// Register bus
`define DORB_ADDR_W 4
`define DORB_DATA_W 32
`define DORB_OFF_CTRL 4'h0
`define DORB_OFF_STATUS 4'h4
`define DORB_OFF_COUNT 4'h8

// ==========================================
// Control register fields
`define DORB_CTRL_W 6
`define DORB_CTRL_DDR 0
`define DORB_CTRL_LATCH 1
`define DORB_CTRL_DSET 2
`define DORB_CTRL_TSET 3
`define DORB_CTRL_RUN 4
`define DORB_CTRL_INIT 5
`define DORB_CTRL_RST 6'h00

// ==========================================
// Status register fields
`define DORB_ST_RISE 0
`define DORB_ST_FALL 1
`define DORB_ST_TRI 2
`define DORB_ST_HEAD 3
`define DORB_ST_FULL 4
`define DORB_ST_UNDER 5

// ==========================================
// Data path
`define DORB_COUNT_W 16
`define DORB_WORD_W 3
`define DORB_BUF_DEPTH 2

`endif

// *** rtl/dorb_out_cell.v ***
// Data output cell: SDR element and generic DDR stages
`timescale 1ns/1ps
`include "dorb_consts.vh"

module dorb_out_cell
(
  // Clock and reset
  input wire mclk_in,
  input wire sys_rst_in,
  // Configuration
  input wire init_in,
  input wire init_val_in,
  input wire ddr_mode_in,
  input wire latch_sel_in,
  // Data from buffer head
  input wire load_in,
  input wire first_data_in,
  input wire second_data_in,
  // Pad side and state
  output wire pad_data_out,
  output wire rise_q_out,
  output wire fall_q_out
);

  reg rising_stage_reg_ff;
  reg rise_second_ff;
  reg falling_stage_reg_ff;
  reg latch_hold_ff;
  wire latch_d;
  wire sdr_q;

  // ==========================================
  // Rising edge capture
  always @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      rising_stage_reg_ff <= 1'b0;
      rise_second_ff <= 1'b0;
    end
    else if (init_in)
    begin
      rising_stage_reg_ff <= init_val_in;
      rise_second_ff <= init_val_in;
    end
    else if (load_in)
    begin
      rising_stage_reg_ff <= first_data_in;
      rise_second_ff <= second_data_in;
    end
  end

  // ==========================================
  // Falling edge stage and latch hold
  always @(negedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      falling_stage_reg_ff <= 1'b0;
      latch_hold_ff <= 1'b0;
    end
    else if (init_in)
    begin
      falling_stage_reg_ff <= init_val_in;
      latch_hold_ff <= init_val_in;
    end
    else
    begin
      falling_stage_reg_ff <= rise_second_ff;
      latch_hold_ff <= latch_d;
    end
  end

  // Latch is open while the clock is high
  assign latch_d = load_in ? first_data_in : rising_stage_reg_ff;
  assign sdr_q = latch_sel_in ? (mclk_in ? latch_d : latch_hold_ff) : rising_stage_reg_ff;

  // Clock-driven mux: high phase first, low phase second
  assign pad_data_out = ddr_mode_in ? (mclk_in ? rising_stage_reg_ff : falling_stage_reg_ff) : sdr_q;
  assign rise_q_out = rising_stage_reg_ff;
  assign fall_q_out = falling_stage_reg_ff;

endmodule // dorb_out_cell

// *** rtl/dorb_pair_buf.v ***
// Two-entry buffer between core stream and output stage
`timescale 1ns/1ps
`include "dorb_consts.vh"

module dorb_pair_buf
(
  // Clock and reset
  input wire mclk_in,
  input wire sys_rst_in,
  // Filling side
  input wire in_valid_in,
  input wire [`DORB_WORD_W-1:0] in_data_in,
  output wire in_ready_out,
  // Draining side
  output wire out_valid_out,
  output wire [`DORB_WORD_W-1:0] out_data_out,
  input wire out_ready_in
);

  reg [`DORB_WORD_W-1:0] slot_ff [0:`DORB_BUF_DEPTH-1];
  reg wr_ptr_ff;
  reg rd_ptr_ff;
  reg [1:0] count_ff;
  reg ready_ff;
  reg [1:0] nxt_count;
  wire push;
  wire pop;

  assign push = in_valid_in && ready_ff;
  assign pop = out_ready_in && (count_ff != 2'h0);
  assign in_ready_out = ready_ff;
  assign out_valid_out = (count_ff != 2'h0);
  assign out_data_out = slot_ff[rd_ptr_ff];

  always @*
  begin
    nxt_count = count_ff;
    if (push && !pop)
      nxt_count = count_ff + 2'h1;
    else if (pop && !push)
      nxt_count = count_ff - 2'h1;
  end

  always @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
      ready_ff <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= ~wr_ptr_ff;
      if (pop)
        rd_ptr_ff <= ~rd_ptr_ff;
      count_ff <= nxt_count;
      ready_ff <= (nxt_count != 2'h2);
    end
  end

  always @(posedge mclk_in)
  begin
    if (push)
      slot_ff[wr_ptr_ff] <= in_data_in;
  end

endmodule // dorb_pair_buf

// *** rtl/dorb_top.v ***
// Top of the DDR output register block with Avalon-MM registers
// ==========================================
// Behaviour
// - SDR: first data through one element
// - SDR element is register or latch
// - DDR: both inputs captured on rising edge
// - Falling edge moves second data onward
// - Clock-driven mux selects rising/falling stage
// - One register holds tri-state control
// - SDR tri-state through one element to pad
// - Each element configurable set or reset
// - Reset clears elements, INIT loads configured value
`timescale 1ns/1ps
`include "dorb_consts.vh"

module dorb_top
(
  // Clock and reset
  input wire mclk_in,
  input wire sys_rst_in,

  // Avalon-MM slave
  input wire [`DORB_ADDR_W-1:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [`DORB_DATA_W-1:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output wire [`DORB_DATA_W-1:0] avs_readdata_out,
  output wire avs_waitrequest_out,

  // Core data stream
  input wire core_valid_in,
  input wire first_data_in,
  input wire second_data_in,
  input wire tristate_ctrl_in,
  output wire core_ready_out,

  // Pad buffer side
  output wire pad_data_out,
  output wire pad_tristate_out
);

  // ==========================================
  // Declarations
  reg [`DORB_CTRL_W-1:0] ctrl_ff;
  reg [`DORB_CTRL_W-1:0] nxt_ctrl;
  reg init_ff;
  reg nxt_init;
  reg under_ff;
  reg nxt_under;
  reg [`DORB_COUNT_W-1:0] count_ff;
  reg [`DORB_COUNT_W-1:0] nxt_count;
  reg wait_ff;
  reg nxt_wait;
  reg [`DORB_DATA_W-1:0] rdata_ff;
  reg [`DORB_DATA_W-1:0] nxt_rdata;
  reg tristate_ff;
  reg nxt_tristate;
  wire req;
  wire take;
  wire wr_take;
  wire ctrl_hit;
  wire status_hit;
  wire count_hit;
  wire head_valid;
  wire [`DORB_WORD_W-1:0] head_word;
  wire [`DORB_WORD_W-1:0] in_word;
  wire buf_ready;
  wire load;
  wire run;
  wire rise_q;
  wire fall_q;
  wire buf_full;

  // ==========================================
  // Address decode
  function addr_is;
    input [`DORB_ADDR_W-1:0] addr;
    input [`DORB_ADDR_W-1:0] offset;
    begin
      addr_is = (addr == offset);
    end
  endfunction

  assign ctrl_hit = addr_is(avs_address_in, `DORB_OFF_CTRL);
  assign status_hit = addr_is(avs_address_in, `DORB_OFF_STATUS);
  assign count_hit = addr_is(avs_address_in, `DORB_OFF_COUNT);

  // ==========================================
  // Bus handshake
  assign req = avs_read_in || avs_write_in;
  assign take = req && !wait_ff;
  assign wr_take = avs_write_in && !wait_ff;

  always @*
  begin
    nxt_wait = 1'b1;
    if (req && wait_ff)
      nxt_wait = 1'b0;
  end

  // ==========================================
  // Read data
  always @*
  begin
    nxt_rdata = rdata_ff;
    if (req && wait_ff)
      nxt_rdata = {`DORB_DATA_W{1'b0}};
    if (req && wait_ff && ctrl_hit)
    begin
      nxt_rdata[`DORB_CTRL_W-1:0] = ctrl_ff;
      nxt_rdata[`DORB_CTRL_INIT] = 1'b0;
    end
    else if (req && wait_ff && status_hit)
    begin
      nxt_rdata[`DORB_ST_RISE] = rise_q;
      nxt_rdata[`DORB_ST_FALL] = fall_q;
      nxt_rdata[`DORB_ST_TRI] = tristate_ff;
      nxt_rdata[`DORB_ST_HEAD] = head_valid;
      nxt_rdata[`DORB_ST_FULL] = buf_full;
      nxt_rdata[`DORB_ST_UNDER] = under_ff;
    end
    else if (req && wait_ff && count_hit)
    begin
      nxt_rdata[`DORB_COUNT_W-1:0] = count_ff;
    end
  end

  // ==========================================
  // Control register
  always @*
  begin
    nxt_ctrl = ctrl_ff;
    nxt_init = 1'b0;
    if (wr_take && ctrl_hit && avs_byteenable_in[0])
    begin
      nxt_ctrl = avs_writedata_in[`DORB_CTRL_W-1:0];
      nxt_ctrl[`DORB_CTRL_INIT] = 1'b0;
      nxt_init = avs_writedata_in[`DORB_CTRL_INIT];
    end
  end

  assign run = ctrl_ff[`DORB_CTRL_RUN];

  // ==========================================
  // Input buffer
  assign in_word = {tristate_ctrl_in, second_data_in, first_data_in};

  dorb_pair_buf i_dorb_pair_buf
  (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(core_valid_in),
    .in_data_in(in_word),
    .in_ready_out(buf_ready),
    .out_valid_out(head_valid),
    .out_data_out(head_word),
    .out_ready_in(run && !init_ff)
  );

  assign load = run && !init_ff && head_valid;
  assign buf_full = !buf_ready;
  assign core_ready_out = buf_ready;

  // ==========================================
  // Underrun flag, set wins over clear
  always @*
  begin
    nxt_under = under_ff;
    if (wr_take && status_hit && avs_byteenable_in[0] && avs_writedata_in[`DORB_ST_UNDER])
      nxt_under = 1'b0;
    if (run && !init_ff && !head_valid)
      nxt_under = 1'b1;
  end

  // ==========================================
  // Word counter
  always @*
  begin
    nxt_count = count_ff;
    if (wr_take && count_hit && (avs_byteenable_in != 4'h0))
      nxt_count = {`DORB_COUNT_W{1'b0}};
    if (load)
      nxt_count = nxt_count + {{(`DORB_COUNT_W-1){1'b0}}, 1'b1};
  end

  // ==========================================
  // Tri-state register
  always @*
  begin
    nxt_tristate = tristate_ff;
    if (init_ff)
      nxt_tristate = ctrl_ff[`DORB_CTRL_TSET];
    else if (load)
      nxt_tristate = head_word[2];
  end

  // ==========================================
  // Registers
  always @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_ff <= `DORB_CTRL_RST;
      init_ff <= 1'b0;
      under_ff <= 1'b0;
      count_ff <= {`DORB_COUNT_W{1'b0}};
      wait_ff <= 1'b1;
      rdata_ff <= {`DORB_DATA_W{1'b0}};
      tristate_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      init_ff <= nxt_init;
      under_ff <= nxt_under;
      count_ff <= nxt_count;
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      tristate_ff <= nxt_tristate;
    end
  end

  assign avs_readdata_out = rdata_ff;
  assign avs_waitrequest_out = wait_ff;
  assign pad_tristate_out = tristate_ff;

  // ==========================================
  // Data output cell
  dorb_out_cell i_dorb_out_cell
  (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .init_in(init_ff),
    .init_val_in(ctrl_ff[`DORB_CTRL_DSET]),
    .ddr_mode_in(ctrl_ff[`DORB_CTRL_DDR]),
    .latch_sel_in(ctrl_ff[`DORB_CTRL_LATCH]),
    .load_in(load),
    .first_data_in(head_word[0]),
    .second_data_in(head_word[1]),
    .pad_data_out(pad_data_out),
    .rise_q_out(rise_q),
    .fall_q_out(fall_q)
  );

endmodule // dorb_top

// *** sim/dorb_pad_model.sv ***
// Pad buffer model driving the external pin
`timescale 1ns/1ps

module dorb_pad_model
(
  // Pad side
  input wire pad_data_in,
  input wire pad_release_in,
  output wire pin_out
);
  // ==========================================
  // Released pin shows inverse of last level
  reg last_drv = 1'b0;
  always @(pad_data_in or pad_release_in)
    if (!pad_release_in)
      last_drv = pad_data_in;
  assign pin_out = pad_release_in ? ~last_drv : pad_data_in;
endmodule // dorb_pad_model

// *** sim/dorb_props_properties.sv ***
// Bus and reset properties of the DDR output block
`timescale 1ns/1ps
`include "dorb_consts.vh"

module dorb_props
(
  // Clock and reset
  input wire mclk_in,
  input wire sys_rst_in,
  // Register bus
  input wire [`DORB_ADDR_W-1:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [`DORB_DATA_W-1:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  // Stream and pad
  input wire core_ready_out,
  input wire pad_tristate_out
);
  // ==========================================
  // Properties
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  wire req = avs_read_in || avs_write_in;
  wire ans = avs_read_in && !avs_waitrequest_out;
  wire mapped = avs_address_in == `DORB_OFF_CTRL || avs_address_in == `DORB_OFF_STATUS
    || avs_address_in == `DORB_OFF_COUNT;
  sequence s_req;
    req && avs_waitrequest_out;
  endsequence
  sequence s_ans;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  property p_one_wait;
    s_req |=> s_ans;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait not one cycle");
  property p_idle;
    !req && avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_rst;
    @(posedge mclk_in) disable iff (1'b0)
    sys_rst_in |=> avs_waitrequest_out && !core_ready_out && !pad_tristate_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_hold;
    !req |=> $stable(avs_readdata_out);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmap;
    ans && !mapped |-> avs_readdata_out == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not 0");
  property p_ctrl_hi;
    ans && avs_address_in == `DORB_OFF_CTRL |-> avs_readdata_out[31:5] == 27'h0;
  endproperty
  a_ctrl_hi: assert property (p_ctrl_hi) else $error("control high bits set");
  property p_st_hi;
    ans && avs_address_in == `DORB_OFF_STATUS |-> avs_readdata_out[31:6] == 26'h0;
  endproperty
  a_st_hi: assert property (p_st_hi) else $error("status high bits set");
  property p_cnt_hi;
    ans && avs_address_in == `DORB_OFF_COUNT |-> avs_readdata_out[31:16] == 16'h0;
  endproperty
  a_cnt_hi: assert property (p_cnt_hi) else $error("count high bits set");
endmodule // dorb_props

// *** sim/dorb_top_tb.sv ***
// Self-checking bench of the DDR output block
`timescale 1ns/1ps
`include "dorb_consts.vh"

module dorb_top_tb;
  // ==========================================
  // Signals
  reg mclk_in = 0;
  reg sys_rst_in = 1;
  reg [3:0] avs_address_in = 0;
  reg avs_read_in = 0;
  reg avs_write_in = 0;
  reg [31:0] avs_writedata_in = 0;
  reg [3:0] avs_byteenable_in = 4'hF;
  reg core_valid_in = 0;
  reg first_data_in = 0;
  reg second_data_in = 0;
  reg tristate_ctrl_in = 0;
  wire [31:0] avs_readdata_out;
  wire avs_waitrequest_out, core_ready_out, pad_data_out, pad_tristate_out, pin_level;
  integer n_errors = 0;
  integer samples_checked = 0;
  integer i, k, m;
  reg [7:0] lfsr = 8'h26;
  reg [31:0] got;

  dorb_top i_dorb_top (.mclk_in, .sys_rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .core_valid_in, .first_data_in, .second_data_in, .tristate_ctrl_in, .core_ready_out,
    .pad_data_out, .pad_tristate_out);
  dorb_pad_model i_dorb_pad_model (.pad_data_in(pad_data_out), .pad_release_in(pad_tristate_out),
    .pin_out(pin_level));

  initial forever #20 mclk_in = ~mclk_in;

  // ==========================================
  // Helpers
  function [7:0] rnd(input [7:0] s);
    rnd = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function exp_pad(input [2:0] w, input ddr, input hi);
    exp_pad = (ddr && !hi) ? w[1] : w[0];
  endfunction
  task conclude;
    begin
      $display("Checks made %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] exp, input [31:0] seen, input [8*8-1:0] what);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
        n_errors = n_errors + 1;
        $display("BAD %0s exp %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge mclk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= w;
      avs_read_in <= !w;
      k = 0;
      @(posedge mclk_in);
      while (avs_waitrequest_out !== 1'b0 && k < 20)
      begin
        k = k + 1;
        @(posedge mclk_in);
      end
      if (k == 20)
      begin
        n_errors = n_errors + 1;
        conclude;
      end
      got = avs_readdata_out;
      avs_read_in <= 0;
      avs_write_in <= 0;
    end
  endtask
  task push(input [2:0] w);
    begin
      @(posedge mclk_in);
      core_valid_in <= 1;
      {tristate_ctrl_in, second_data_in, first_data_in} <= w;
      k = 0;
      @(posedge mclk_in);
      while (core_ready_out !== 1'b1 && k < 20)
      begin
        k = k + 1;
        @(posedge mclk_in);
      end
      if (k == 20)
      begin
        n_errors = n_errors + 1;
        conclude;
      end
      core_valid_in <= 0;
    end
  endtask
  task show(input [2:0] w, input ddr);
    begin
      push(w);
      repeat (3) @(posedge mclk_in);
      #10;
      chk(exp_pad(w, ddr, 1'b1), pad_data_out, "pad_hi");
      chk(w[2], pad_tristate_out, "tri");
      if (!w[2])
        chk(exp_pad(w, ddr, 1'b1), pin_level, "pin");
      @(negedge mclk_in);
      #10;
      chk(exp_pad(w, ddr, 1'b0), pad_data_out, "pad_lo");
      if (ddr)
      begin
        bus(0, `DORB_OFF_STATUS, 0);
        chk(w, got[2:0], "st_stage");
      end
    end
  endtask

  // ==========================================
  // Scenarios
  initial
  begin
    repeat (20) @(posedge mclk_in);
    sys_rst_in <= 0;
    for (i = 0; i < 16; i = i + 4)
    begin
      bus(0, i[3:0], 0);
      chk(0, got, "reg_rst");
    end
    @(negedge mclk_in);
    #10;
    chk(2'h0, {pad_data_out, pad_tristate_out}, "pad_rst");
    bus(1, 4'hC, 32'hFFFFFFFF);
    bus(0, 4'hC, 0);
    chk(0, got, "unmapped");
    avs_byteenable_in <= 4'hE;
    bus(1, `DORB_OFF_CTRL, 32'h1F);
    avs_byteenable_in <= 4'hF;
    bus(0, `DORB_OFF_CTRL, 0);
    chk(0, got, "ben_ctrl");
    push(3'h5);
    push(3'h3);
    @(negedge mclk_in);
    chk(0, core_ready_out, "full");
    bus(0, `DORB_OFF_STATUS, 0);
    chk(32'h18, got, "st_full");
    for (m = 0; m < 3; m = m + 1)
    begin
      bus(1, `DORB_OFF_CTRL, {27'h0, 3'h4, m == 1, m == 2});
      for (i = 0; i < 8; i = i + 1)
      begin
        lfsr = rnd(lfsr);
        show(lfsr[2:0], m == 2);
      end
    end
    bus(0, `DORB_OFF_STATUS, 0);
    chk(1, got[5], "underrun");
    bus(1, `DORB_OFF_CTRL, 0);
    bus(1, `DORB_OFF_STATUS, 32'h20);
    bus(0, `DORB_OFF_STATUS, 0);
    chk({29'h0, lfsr[2:0]}, got, "st_clr");
    bus(0, `DORB_OFF_COUNT, 0);
    chk(26, got, "count");
    bus(1, `DORB_OFF_COUNT, 0);
    bus(0, `DORB_OFF_COUNT, 0);
    chk(0, got, "cnt_clr");
    for (i = 0; i < 2; i = i + 1)
    begin
      bus(1, `DORB_OFF_CTRL, {26'h0, 2'h2, i[0], i[0], 2'h0});
      repeat (2) @(posedge mclk_in);
      @(negedge mclk_in);
      #10;
      chk({i[0], i[0]}, {pad_data_out, pad_tristate_out}, "init");
    end
    @(posedge mclk_in);
    sys_rst_in <= 1;
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 0;
    @(negedge mclk_in);
    #10;
    chk(2'h0, {pad_data_out, pad_tristate_out}, "rst2");
    conclude;
  end
endmodule // dorb_top_tb

bind dorb_top dorb_props i_dorb_props (.mclk_in, .sys_rst_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .core_ready_out, .pad_tristate_out);
